/* File: psr_consts.vh */
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

// Register address width and byte offsets
`define PSR_ADDR_W            12
`define PSR_OFF_CTRL_A        12'h040
`define PSR_OFF_CTRL_B        12'h044

// Reset values
`define PSR_RST_CTRL_A        32'h00000000
`define PSR_RST_CTRL_B        32'h00000000

// Implemented bits of control register a
`define PSR_IMPL_A            32'h01100008
// Implemented bits of control register b
`define PSR_IMPL_B            32'h07071011

// Field positions, control register a
`define PSR_BIT_BUS_CTRL      24
`define PSR_BIT_PWM           20
`define PSR_BIT_WATCHDOG      3

// Field positions, control register b
`define PSR_BIT_CMP0          24
`define PSR_BIT_GPC0          16
`define PSR_BIT_TWO_WIRE      12
`define PSR_BIT_SYNC_SERIAL   4
`define PSR_BIT_ASYNC_SERIAL  0

// Unit count of comparators and general-purpose counters
`define PSR_NUM_TRIPLE        3

`endif

/* File: psr_ctrl_reg.v */
`timescale 1ns/100ps
`default_nettype none

// One 32-bit masked reset control register
module psr_ctrl_reg (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_reset_n,
  // Write port
  input  wire        i_wr_en,
  input  wire [31:0] i_wr_data,
  // Capability mask and implemented-bit mask
  input  wire [31:0] i_cap_mask,
  input  wire [31:0] i_impl_mask,
  // Register value
  output wire [31:0] o_value
);

  reg  [31:0] value_q;
  wire [31:0] wr_mask;

  // Only implemented bits that the capability mask allows take the write
  assign wr_mask = i_cap_mask & i_impl_mask;

  // Masked update; unwritable positions keep their value, reserved stay zero
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      value_q <= 32'h00000000;
    end else if (i_wr_en) begin
      value_q <= ((value_q & ~wr_mask) | (i_wr_data & wr_mask)) & i_impl_mask;
    end
  end

  assign o_value = value_q;

endmodule // psr_ctrl_reg

`default_nettype wire

/* File: psr_reset_drv.v */
`timescale 1ns/100ps
`default_nettype none

// Registered reset output for one peripheral, released on the clock
module psr_reset_drv (
  // Clock and reset
  input  wire i_clk_sys,
  input  wire i_reset_n,
  // Control bit
  input  wire i_hold,
  // Reset to the peripheral, active low
  output wire o_periph_rst_n
);

  reg rst_n_q;

  // Flop gives a glitch-free, clock-aligned release
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rst_n_q <= 1'b0;
    end else begin
      rst_n_q <= ~i_hold;
    end
  end

  assign o_periph_rst_n = rst_n_q;

endmodule // psr_reset_drv

`default_nettype wire

/* File: psr_soft_reset.v */
// Summary of operation
// [RQ1] Writes only change bits enabled by the matching capability mask.
// [RQ2] Both control registers are 32-bit read-write and clear to zero on reset.
// [RQ3] Register a bit 24 resets the bus controller unit.
// [RQ4] Register a bit 20 resets the pulse-width modulation module.
// [RQ5] Register a bit 3 resets the watchdog.
// [RQ6] Register b bits 26..24 reset comparators two, one, zero.
// [RQ7] Register b bits 18..16 reset general-purpose counters two, one, zero.
// [RQ8] Register b bit 12 resets the two-wire unit.
// [RQ9] Register b bit 4 resets the synchronous serial unit.
// [RQ10] Register b bit 0 resets the asynchronous serial unit.
// [RQ11] All unassigned bits read zero and ignore writes.
// [RQ12] Software should preserve unassigned bits across read-modify-write.
// [RQ13] A set bit holds its unit in reset; clearing releases on the clock.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "psr_consts.vh"

module psr_soft_reset (
  // Clock and reset
  input  wire                     i_clk_sys,
  input  wire                     i_reset_n,
  // Register port
  input  wire [`PSR_ADDR_W-1:0]   i_addr,
  input  wire [31:0]              i_wdata,
  input  wire                     i_wr,
  input  wire                     i_rd,
  output wire [31:0]              o_rdata,
  // Capability masks from system control
  input  wire [31:0]              i_capability_mask_a,
  input  wire [31:0]              i_capability_mask_b,
  // Peripheral resets, active low
  output wire                     o_bus_controller_rst_n,
  output wire                     o_pwm_rst_n,
  output wire                     o_watchdog_rst_n,
  output wire [`PSR_NUM_TRIPLE-1:0] o_comparator_rst_n,
  output wire [`PSR_NUM_TRIPLE-1:0] o_gp_counter_rst_n,
  output wire                     o_two_wire_rst_n,
  output wire                     o_sync_serial_rst_n,
  output wire                     o_async_serial_rst_n
);

  wire [31:0] soft_reset_control_a;
  wire [31:0] soft_reset_control_b;
  wire        sel_a;
  wire        sel_b;
  reg  [31:0] rdata_q;
  reg  [31:0] rdata_d;

  // Address decode
  assign sel_a = (i_addr == `PSR_OFF_CTRL_A);
  assign sel_b = (i_addr == `PSR_OFF_CTRL_B);

  // [RQ1] masked write, register a
  // [RQ2] cleared on reset
  psr_ctrl_reg u_ctrl_a (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_wr_en     (i_wr & sel_a),
    .i_wr_data   (i_wdata),
    .i_cap_mask  (i_capability_mask_a),
    .i_impl_mask (`PSR_IMPL_A),
    .o_value     (soft_reset_control_a)
  );

  // [RQ1] masked write, register b
  // [RQ11] reserved bits fixed
  psr_ctrl_reg u_ctrl_b (
    .i_clk_sys   (i_clk_sys),
    .i_reset_n   (i_reset_n),
    .i_wr_en     (i_wr & sel_b),
    .i_wr_data   (i_wdata),
    .i_cap_mask  (i_capability_mask_b),
    .i_impl_mask (`PSR_IMPL_B),
    .o_value     (soft_reset_control_b)
  );

  // Read mux; unmapped addresses read zero
  always @* begin
    rdata_d = 32'h00000000;
    if (sel_a) begin
      rdata_d = soft_reset_control_a;
    end else if (sel_b) begin
      rdata_d = soft_reset_control_b;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge i_clk_sys) begin
    if (!i_reset_n) begin
      rdata_q <= 32'h00000000;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 32'h00000000;
    end
  end

  assign o_rdata = rdata_q;

  // [RQ3] bus controller reset
  // [RQ13] registered release
  psr_reset_drv u_rst_bus (
    .i_clk_sys      (i_clk_sys),
    .i_reset_n      (i_reset_n),
    .i_hold         (soft_reset_control_a[`PSR_BIT_BUS_CTRL]),
    .o_periph_rst_n (o_bus_controller_rst_n)
  );

  // [RQ4] modulator reset
  psr_reset_drv u_rst_pwm (
    .i_clk_sys      (i_clk_sys),
    .i_reset_n      (i_reset_n),
    .i_hold         (soft_reset_control_a[`PSR_BIT_PWM]),
    .o_periph_rst_n (o_pwm_rst_n)
  );

  // [RQ5] watchdog reset
  psr_reset_drv u_rst_wdog (
    .i_clk_sys      (i_clk_sys),
    .i_reset_n      (i_reset_n),
    .i_hold         (soft_reset_control_a[`PSR_BIT_WATCHDOG]),
    .o_periph_rst_n (o_watchdog_rst_n)
  );

  // Comparators and counters share one loop
  genvar gi;
  generate
    for (gi = 0; gi < `PSR_NUM_TRIPLE; gi = gi + 1) begin : g_triple
      // [RQ6] comparator resets
      psr_reset_drv u_rst_cmp (
        .i_clk_sys      (i_clk_sys),
        .i_reset_n      (i_reset_n),
        .i_hold         (soft_reset_control_b[`PSR_BIT_CMP0 + gi]),
        .o_periph_rst_n (o_comparator_rst_n[gi])
      );
      // [RQ7] counter resets
      psr_reset_drv u_rst_gpc (
        .i_clk_sys      (i_clk_sys),
        .i_reset_n      (i_reset_n),
        .i_hold         (soft_reset_control_b[`PSR_BIT_GPC0 + gi]),
        .o_periph_rst_n (o_gp_counter_rst_n[gi])
      );
    end
  endgenerate

  // [RQ8] two-wire reset
  psr_reset_drv u_rst_twi (
    .i_clk_sys      (i_clk_sys),
    .i_reset_n      (i_reset_n),
    .i_hold         (soft_reset_control_b[`PSR_BIT_TWO_WIRE]),
    .o_periph_rst_n (o_two_wire_rst_n)
  );

  // [RQ9] sync serial reset
  psr_reset_drv u_rst_ssi (
    .i_clk_sys      (i_clk_sys),
    .i_reset_n      (i_reset_n),
    .i_hold         (soft_reset_control_b[`PSR_BIT_SYNC_SERIAL]),
    .o_periph_rst_n (o_sync_serial_rst_n)
  );

  // [RQ10] async serial reset
  psr_reset_drv u_rst_uart (
    .i_clk_sys      (i_clk_sys),
    .i_reset_n      (i_reset_n),
    .i_hold         (soft_reset_control_b[`PSR_BIT_ASYNC_SERIAL]),
    .o_periph_rst_n (o_async_serial_rst_n)
  );

endmodule // psr_soft_reset

`default_nettype wire

/* File: psr_soft_reset_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
`include "psr_consts.vh"
// Port-level checks; registers are seen only through reads and reset outputs
module psr_soft_reset_asserts (
  input wire logic [`PSR_ADDR_W-1:0] i_addr,
  input wire logic [31:0]            i_wdata,
  input wire logic [31:0]            o_rdata,
  input wire logic [31:0]            i_capability_mask_a,
  input wire logic [31:0]            i_capability_mask_b,
  input wire logic [2:0]             o_comparator_rst_n,
  input wire logic [2:0]             o_gp_counter_rst_n,
  input wire logic                   i_clk_sys,
  input wire logic                   i_reset_n,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic                   o_bus_controller_rst_n,
  input wire logic                   o_watchdog_rst_n
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  // Enabled write, then a cycle without a second write there
  sequence s_wr(a, m);
    i_wr && i_addr == a && m ##1 !(i_wr && i_addr == a);
  endsequence
  property p_resv_a; $past(i_rd) && $past(i_addr) == `PSR_OFF_CTRL_A |-> (o_rdata & ~`PSR_IMPL_A) == 0; endproperty
  property p_resv_b; $past(i_rd) && $past(i_addr) == `PSR_OFF_CTRL_B |-> (o_rdata & ~`PSR_IMPL_B) == 0; endproperty
  property p_rdback; s_wr(`PSR_OFF_CTRL_A, &i_capability_mask_a) ##0 i_rd && i_addr == `PSR_OFF_CTRL_A
    |=> o_rdata == ($past(i_wdata, 2) & `PSR_IMPL_A); endproperty
  property p_masked; i_wr && i_addr == `PSR_OFF_CTRL_A && !i_capability_mask_a[3] |-> ##2 $stable(o_watchdog_rst_n);
  endproperty
  property p_bus; s_wr(`PSR_OFF_CTRL_A, i_capability_mask_a[24]) |=> o_bus_controller_rst_n == !$past(i_wdata[24], 2);
  endproperty
  property p_wd; s_wr(`PSR_OFF_CTRL_A, i_capability_mask_a[3]) |=> o_watchdog_rst_n == !$past(i_wdata[3], 2);
  endproperty
  property p_cmp; s_wr(`PSR_OFF_CTRL_B, &i_capability_mask_b[26:24])
    |=> o_comparator_rst_n == ~$past(i_wdata[26:24], 2);
  endproperty
  property p_gpc; s_wr(`PSR_OFF_CTRL_B, &i_capability_mask_b[18:16])
    |=> o_gp_counter_rst_n == ~$past(i_wdata[18:16], 2);
  endproperty
  a_resv_a: assert property (p_resv_a) else $error("reserved bit set in register a");
  a_resv_b: assert property (p_resv_b) else $error("reserved bit set in register b");
  a_rdback: assert property (p_rdback) else $error("read after write differs");
  a_masked: assert property (p_masked) else $error("masked bit changed");
  a_bus: assert property (p_bus) else $error("bus controller reset wrong");
  a_wd: assert property (p_wd) else $error("watchdog reset wrong");
  a_cmp: assert property (p_cmp) else $error("comparator resets wrong");
  a_gpc: assert property (p_gpc) else $error("counter resets wrong");
endmodule // psr_soft_reset_asserts
bind psr_soft_reset psr_soft_reset_asserts u_chk (.i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
  .i_capability_mask_a(i_capability_mask_a), .i_capability_mask_b(i_capability_mask_b),
  .o_comparator_rst_n(o_comparator_rst_n), .o_gp_counter_rst_n(o_gp_counter_rst_n), .i_clk_sys(i_clk_sys),
  .i_reset_n(i_reset_n), .i_wr(i_wr), .i_rd(i_rd), .o_bus_controller_rst_n(o_bus_controller_rst_n),
  .o_watchdog_rst_n(o_watchdog_rst_n));
`default_nettype wire

/* File: psr_soft_reset_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "psr_consts.vh"
module psr_soft_reset_test;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [11:0] addr = 0, a;
  logic [31:0] wdata = 0, ma = 0, mb = 0, ea = 0, eb = 0, rdata, ra, rb;
  wire  [11:0] rv;
  int          err_total = 0, comparisons = 0, cyc = 0;
  psr_soft_reset dut (.i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_capability_mask_a(ma), .i_capability_mask_b(mb), .o_bus_controller_rst_n(rv[11]),
    .o_pwm_rst_n(rv[10]), .o_watchdog_rst_n(rv[9]), .o_comparator_rst_n(rv[8:6]), .o_gp_counter_rst_n(rv[5:3]),
    .o_two_wire_rst_n(rv[2]), .o_sync_serial_rst_n(rv[1]), .o_async_serial_rst_n(rv[0]));
  initial forever #5 clk = ~clk;
  // Masked update; unassigned bits never stick
  function automatic logic [31:0] upd(logic [31:0] o, d, m, im);
    return ((o & ~m) | (d & m)) & im;
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Peripheral reset outputs, active low, in port order
  task automatic chk_rst(logic [11:0] e, logic [11:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value resets expected %h seen %h", e, g);
    end
  endtask
  // Entered just after an edge; writes are always followed by a read
  task automatic wrt(logic [11:0] ad, logic [31:0] d, m_a, m_b);
    wr <= 1; addr <= ad; wdata <= d; ma <= m_a; mb <= m_b;
    @(posedge clk);
    wr <= 0;
    if (ad == `PSR_OFF_CTRL_A) ea = upd(ea, d, m_a, `PSR_IMPL_A);
    if (ad == `PSR_OFF_CTRL_B) eb = upd(eb, d, m_b, `PSR_IMPL_B);
  endtask
  // Read data and reset outputs both settle one edge after the strobe
  task automatic rdc(logic [11:0] ad);
    rd <= 1; addr <= ad;
    @(posedge clk);
    rd <= 0;
    #1;
    chk("read", ad == `PSR_OFF_CTRL_A ? ea : ad == `PSR_OFF_CTRL_B ? eb : 32'h0, rdata);
    chk_rst(~{ea[24], ea[20], ea[3], eb[26:24], eb[18:16], eb[12], eb[4], eb[0]}, rv);
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(24));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    rdc(`PSR_OFF_CTRL_A);
    rdc(`PSR_OFF_CTRL_B);
    wrt(`PSR_OFF_CTRL_A, 32'hffffffff, 32'hffffffff, 32'h0);
    rdc(`PSR_OFF_CTRL_A);
    wrt(`PSR_OFF_CTRL_B, 32'hffffffff, 32'h0, 32'hffffffff);
    rdc(`PSR_OFF_CTRL_B);
    wrt(`PSR_OFF_CTRL_A, 32'h0, 32'h0, 32'h0);
    rdc(`PSR_OFF_CTRL_A);
    // Read-modify-write: only the modulator bit changes, unassigned bits go back as read
    wrt(`PSR_OFF_CTRL_A, rdata ^ 32'h00100000, 32'hffffffff, 32'hffffffff);
    rdc(`PSR_OFF_CTRL_A);
    rdc(12'h048);
    repeat (80) begin
      a = $urandom_range(2) == 0 ? 12'($urandom) & 12'hffc : $urandom_range(1) ? `PSR_OFF_CTRL_A : `PSR_OFF_CTRL_B;
      ra = $urandom_range(3) == 0 ? 32'hffffffff : $urandom;
      rb = $urandom_range(3) == 0 ? 32'hffffffff : $urandom;
      wrt(a, $urandom, ra, rb);
      rdc(a);
      rdc(a ^ 12'h004);
    end
    wrt(`PSR_OFF_CTRL_B, 32'hffffffff, 32'hffffffff, 32'hffffffff);
    rdc(`PSR_OFF_CTRL_B);
    // Mid-run reset with units held: every unit reset must be asserted during it
    rst_n <= 0;
    @(posedge clk);
    #1;
    chk_rst(12'h000, rv);
    @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    ea = 0;
    eb = 0;
    rdc(`PSR_OFF_CTRL_A);
    rdc(`PSR_OFF_CTRL_B);
    report_and_stop;
  end
endmodule // psr_soft_reset_test
`default_nettype wire
